// >>> common/lcd_pkg.sv
// What this block does
// RULE_01: Loop-up present clears when more than 600 received bits miss the loop-up pattern in one 39.8 ms period.
// RULE_02: Loop-up present sets once more than 126 consecutive 39.8 ms periods each show fewer than 600 misses.
// RULE_03: Loop-down present clears when more than 600 received bits miss the loop-down pattern in one 39.8 ms period.
// RULE_04: Loop-down present sets once more than 126 consecutive 39.8 ms periods each show fewer than 600 misses.
// RULE_05: The loop-up code is pattern bits 7 down to 3, 2, 1 or 0 as its length select says; lower bits are ignored.
// RULE_06: The loop-down code is pattern bits 7 down to 3, 2, 1 or 0 as its length select says; lower bits are ignored.
// RULE_07: Loop-up pattern bit 7 is compared with the first received code bit, then successively lower bits.
// RULE_08: Loop-down pattern bit 7 is compared with the first received code bit, then successively lower bits.
// RULE_09: The loop-up change flag sets on every edge of loop-up present and clears only when software writes a one.
// RULE_10: The loop-down change flag sets on every edge of loop-down present and clears only when software writes a one.
// RULE_11: The loop-up change flag reaches the interrupt output only while its enable bit is one.
// RULE_12: The loop-down change flag reaches the interrupt output only while its enable bit is one.
// RULE_13: Loop-up length select 00 gives 5 bits, 01 gives 6 or 3, 10 gives 7, 11 gives 8 or 4.
// RULE_14: Loop-down length select uses the same mapping of 5, 6 or 3, 7, and 8 or 4 bits.
// RULE_15: With framing-bit skip at one framing bits are left out; at zero they are compared and the result dropped.
// RULE_16: The active-low interrupt is low while any enabled change flag is one and released once all are clear.
// RULE_17: Reset clears both present bits and both flags and restarts period counting from a period start.
package lcd_pkg;

	// ----------------------------------------
	// Register indices and byte address width
	// ----------------------------------------
	localparam logic [7:0] LCD_CFG_IDX = 8'h76;
	localparam logic [7:0] LCD_STATUS_IDX = 8'h77;
	localparam logic [7:0] LCD_UP_PAT_IDX = 8'h78;
	localparam logic [7:0] LCD_DOWN_PAT_IDX = 8'h79;
	localparam logic [7:0] LCD_IRQ_EN_IDX = 8'h7a;
	localparam logic [7:0] LCD_FLAGS_IDX = 8'h7b;
	localparam int LCD_ADDR_W = 12;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int LCD_UP_BIT = 1;
	localparam int LCD_DOWN_BIT = 0;
	localparam int LCD_SKIP_BIT = 4;
	localparam logic [7:0] LCD_CFG_RST = 8'h04;
	localparam logic [7:0] LCD_UP_PAT_RST = 8'h08;
	localparam logic [7:0] LCD_DOWN_PAT_RST = 8'h24;
	localparam logic [7:0] LCD_IRQ_EN_RST = 8'h00;
	localparam logic [3:0] LCD_MIN_LEN = 4'h5;

	// ----------------------------------------
	// Timing and thresholds
	// ----------------------------------------
	localparam real LCD_CLK_MHZ = 20.0;
	localparam real LCD_PERIOD_MS = 39.8;
	localparam int LCD_PERIOD_CYC = $rtoi(LCD_PERIOD_MS * 1000.0 * LCD_CLK_MHZ);
	localparam int LCD_ERR_LIMIT = 600;
	localparam int LCD_GOOD_RUN = 126;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic framing_bit_skip;
		logic [1:0] loop_down_len_sel;
		logic [1:0] loop_up_len_sel;
	} lcd_cfg_s;

	typedef struct packed {
		logic valid;
		logic data;
		logic framing;
	} lcd_rx_bit_s;

endpackage : lcd_pkg

// >>> src/lcd_top.sv
`timescale 1ns/1ps

// ----------------------------------------
// One pattern matcher with period judgement
// ----------------------------------------
module lcd_matcher
	import lcd_pkg::*;
#(
	parameter int ERR_W = 20
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] pattern,
	input wire logic [1:0] len_sel,
	input wire logic skip,
	input wire lcd_rx_bit_s rx,
	input wire logic period_end,
	output logic present_r
);

	logic [2:0] phase_r;
	logic [2:0] phase_nxt;
	logic [ERR_W-1:0] err_r;
	logic [ERR_W-1:0] err_nxt;
	logic [6:0] run_r;
	logic [6:0] run_nxt;
	logic present_nxt;

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (ERR_W < $clog2(LCD_ERR_LIMIT + 2))
	begin : g_bad_err_w
		$error("ERR_W too narrow for the error limit");
	end

	if (LCD_GOOD_RUN > 127)
	begin : g_bad_run
		$error("Good-period limit exceeds the run counter");
	end

	// ----------------------------------------
	// Bit comparison
	// ----------------------------------------
	wire [3:0] code_len = LCD_MIN_LEN + {2'b00, len_sel}; // RULE_13 RULE_14
	wire [2:0] last_phase = 3'(code_len - 4'h1);
	wire [2:0] bit_pos = 3'(3'h7 - phase_r); // RULE_07 RULE_08
	wire expected = pattern[bit_pos]; // RULE_05 RULE_06
	wire step = rx.valid & ~(rx.framing & skip); // RULE_15
	wire counted = rx.valid & ~rx.framing; // RULE_15
	wire miss = counted & (rx.data != expected);
	wire err_full = &err_r;

	// Hunting: a miss holds the phase, slipping one bit against the stream
	assign phase_nxt = !step ? phase_r :
		miss ? phase_r :
		(phase_r >= last_phase) ? 3'h0 :
		3'(phase_r + 3'h1);

	// ----------------------------------------
	// Period judgement
	// ----------------------------------------
	wire good = err_r < ERR_W'(LCD_ERR_LIMIT);
	wire bad = err_r > ERR_W'(LCD_ERR_LIMIT);
	wire run_done = run_r >= 7'(LCD_GOOD_RUN);

	assign err_nxt = period_end ? {{(ERR_W-1){1'b0}}, miss} :
		(miss & ~err_full) ? ERR_W'(err_r + 1'b1) :
		err_r;

	assign run_nxt = !period_end ? run_r :
		!good ? 7'h00 :
		(&run_r) ? run_r :
		7'(run_r + 7'h01);

	assign present_nxt = !period_end ? present_r :
		bad ? 1'b0 : // RULE_01 RULE_03
		(good & run_done) ? 1'b1 : // RULE_02 RULE_04
		present_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase_r <= 3'h0;
			err_r <= '0;
			run_r <= 7'h00;
			present_r <= 1'b0; // RULE_17
		end
		else
		begin
			phase_r <= phase_nxt;
			err_r <= err_nxt;
			run_r <= run_nxt;
			present_r <= present_nxt;
		end
	end

endmodule : lcd_matcher

// ----------------------------------------
// Loop code detector with APB registers
// ----------------------------------------
module lcd_top
	import lcd_pkg::*;
#(
	parameter int PERIOD_CYCLES = LCD_PERIOD_CYC
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [LCD_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_bit_valid,
	input wire logic rx_bit,
	input wire logic rx_framing_bit,
	output logic irq_n
);

	localparam int PER_W = $clog2(PERIOD_CYCLES + 1);
	localparam int ERR_MIN_W = $clog2(LCD_ERR_LIMIT + 2);
	localparam int ERR_W = (PER_W + 1 > ERR_MIN_W) ? PER_W + 1 : ERR_MIN_W;

	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	if (PERIOD_CYCLES < 2)
	begin : g_bad_period
		$error("PERIOD_CYCLES must be at least 2");
	end

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	lcd_cfg_s cfg_r;
	logic [7:0] up_pat_r;
	logic [7:0] down_pat_r;
	logic up_irq_en_r;
	logic down_irq_en_r;
	logic up_flag_r;
	logic down_flag_r;
	logic up_prev_r;
	logic down_prev_r;
	logic [PER_W-1:0] per_cnt_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic irq_n_r;
	logic loop_up_present;
	logic loop_down_present;
	lcd_rx_bit_s rx;

	assign rx.valid = rx_bit_valid;
	assign rx.data = rx_bit;
	assign rx.framing = rx_framing_bit;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	wire [LCD_ADDR_W-1:0] a_cfg = {2'b00, LCD_CFG_IDX, 2'b00};
	wire [LCD_ADDR_W-1:0] a_status = {2'b00, LCD_STATUS_IDX, 2'b00};
	wire [LCD_ADDR_W-1:0] a_up = {2'b00, LCD_UP_PAT_IDX, 2'b00};
	wire [LCD_ADDR_W-1:0] a_down = {2'b00, LCD_DOWN_PAT_IDX, 2'b00};
	wire [LCD_ADDR_W-1:0] a_en = {2'b00, LCD_IRQ_EN_IDX, 2'b00};
	wire [LCD_ADDR_W-1:0] a_flags = {2'b00, LCD_FLAGS_IDX, 2'b00};

	wire hit_cfg = paddr == a_cfg;
	wire hit_status = paddr == a_status;
	wire hit_up = paddr == a_up;
	wire hit_down = paddr == a_down;
	wire hit_en = paddr == a_en;
	wire hit_flags = paddr == a_flags;
	wire hit_any = hit_cfg | hit_status | hit_up | hit_down | hit_en | hit_flags;

	wire setup = psel & ~penable;
	wire access = psel & penable & pready_r;
	wire wr = access & pwrite & hit_any;

	wire [7:0] status_val = (8'h01 << LCD_UP_BIT) & {8{loop_up_present}} |
		(8'h01 << LCD_DOWN_BIT) & {8{loop_down_present}};
	wire [7:0] en_val = (8'h01 << LCD_UP_BIT) & {8{up_irq_en_r}} |
		(8'h01 << LCD_DOWN_BIT) & {8{down_irq_en_r}};
	wire [7:0] flags_val = (8'h01 << LCD_UP_BIT) & {8{up_flag_r}} |
		(8'h01 << LCD_DOWN_BIT) & {8{down_flag_r}};

	wire [7:0] rd_byte;
	assign rd_byte = hit_cfg ? {3'b000, cfg_r} :
		hit_status ? status_val :
		hit_up ? up_pat_r :
		hit_down ? down_pat_r :
		hit_en ? en_val :
		hit_flags ? flags_val :
		8'h00;

	// ----------------------------------------
	// APB response
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			pready_r <= setup;
			pslverr_r <= setup & ~hit_any;
			if (setup)
			begin
				prdata_r <= {24'h00_0000, pwrite ? 8'h00 : rd_byte};
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_r <= lcd_cfg_s'(LCD_CFG_RST[4:0]);
			up_pat_r <= LCD_UP_PAT_RST;
			down_pat_r <= LCD_DOWN_PAT_RST;
			up_irq_en_r <= LCD_IRQ_EN_RST[LCD_UP_BIT];
			down_irq_en_r <= LCD_IRQ_EN_RST[LCD_DOWN_BIT];
		end
		else if (wr)
		begin
			if (hit_cfg)
			begin
				cfg_r <= lcd_cfg_s'(pwdata[LCD_SKIP_BIT:0]);
			end
			if (hit_up)
			begin
				up_pat_r <= pwdata[7:0];
			end
			if (hit_down)
			begin
				down_pat_r <= pwdata[7:0];
			end
			if (hit_en)
			begin
				up_irq_en_r <= pwdata[LCD_UP_BIT];
				down_irq_en_r <= pwdata[LCD_DOWN_BIT];
			end
		end
	end

	// ----------------------------------------
	// Fixed measurement period
	// ----------------------------------------
	wire period_end = per_cnt_r == PER_W'(PERIOD_CYCLES - 1);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			per_cnt_r <= '0; // RULE_17
		end
		else
		begin
			per_cnt_r <= period_end ? '0 : PER_W'(per_cnt_r + 1'b1);
		end
	end

	// ----------------------------------------
	// Matchers
	// ----------------------------------------
	lcd_matcher #(
		.ERR_W(ERR_W)
	) u_up (
		.pclk(pclk),
		.presetn(presetn),
		.pattern(up_pat_r),
		.len_sel(cfg_r.loop_up_len_sel),
		.skip(cfg_r.framing_bit_skip),
		.rx(rx),
		.period_end(period_end),
		.present_r(loop_up_present)
	);

	lcd_matcher #(
		.ERR_W(ERR_W)
	) u_down (
		.pclk(pclk),
		.presetn(presetn),
		.pattern(down_pat_r),
		.len_sel(cfg_r.loop_down_len_sel),
		.skip(cfg_r.framing_bit_skip),
		.rx(rx),
		.period_end(period_end),
		.present_r(loop_down_present)
	);

	// ----------------------------------------
	// Change flags and interrupt
	// ----------------------------------------
	wire up_edge = loop_up_present ^ up_prev_r;
	wire down_edge = loop_down_present ^ down_prev_r;
	wire up_clr = wr & hit_flags & pwdata[LCD_UP_BIT];
	wire down_clr = wr & hit_flags & pwdata[LCD_DOWN_BIT];
	wire up_flag_nxt = up_edge | (up_flag_r & ~up_clr); // RULE_09
	wire down_flag_nxt = down_edge | (down_flag_r & ~down_clr); // RULE_10
	wire irq_nxt = (up_flag_nxt & up_irq_en_r) | // RULE_11
		(down_flag_nxt & down_irq_en_r); // RULE_12

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			up_prev_r <= 1'b0;
			down_prev_r <= 1'b0;
			up_flag_r <= 1'b0; // RULE_17
			down_flag_r <= 1'b0;
			irq_n_r <= 1'b1;
		end
		else
		begin
			up_prev_r <= loop_up_present;
			down_prev_r <= loop_down_present;
			up_flag_r <= up_flag_nxt;
			down_flag_r <= down_flag_nxt;
			irq_n_r <= ~irq_nxt; // RULE_16
		end
	end

	assign irq_n = irq_n_r;

endmodule : lcd_top

// >>> verification/lcd_top_properties.sv
`timescale 1ns/1ps
module lcd_top_properties
	import lcd_pkg::*;
#(
	parameter int PERIOD_CYCLES = LCD_PERIOD_CYC
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [LCD_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rx_bit_valid,
	input wire logic rx_bit,
	input wire logic rx_framing_bit,
	input wire logic irq_n
);
	localparam logic [11:0] A_LO = {2'h0, LCD_CFG_IDX, 2'h0};
	localparam logic [11:0] A_EN = {2'h0, LCD_IRQ_EN_IDX, 2'h0};
	localparam logic [11:0] A_FL = {2'h0, LCD_FLAGS_IDX, 2'h0};
	int pc_r;
	wire acc = psel && penable && pready && pwrite;
	wire en_acc = acc && paddr == A_EN;
	wire fl_acc = acc && paddr == A_FL;
	wire bad = paddr < A_LO || paddr > A_FL || paddr[1:0] != 2'h0;
	// Period phase counter
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pc_r <= 0;
		else
			pc_r <= (pc_r == PERIOD_CYCLES - 1) ? 0 : pc_r + 1;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rst_quiet; $rose(presetn) |-> irq_n && !pready; endproperty
	property p_irq_fall; $fell(irq_n) |-> pc_r < 6 || $past(en_acc) || $past(en_acc, 2); endproperty
	property p_irq_rise; $rose(irq_n) |-> $past(acc) || $past(acc, 2); endproperty
	property p_w0_keep; fl_acc && pwdata[1:0] == 2'h0 && !irq_n |=> !irq_n [*2]; endproperty
	property p_ready_next; psel && !penable |=> pready; endproperty
	property p_ready_pulse; pready |=> !pready; endproperty
	property p_err_map; psel && !penable && bad |=> pslverr && prdata == 32'h0; endproperty
	property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("busy after reset");
	a_irq_fall: assert property (p_irq_fall) else $error("irq without cause");
	a_irq_rise: assert property (p_irq_rise) else $error("irq released alone");
	a_w0_keep: assert property (p_w0_keep) else $error("zero write cleared");
	a_ready_next: assert property (p_ready_next) else $error("no ready");
	a_ready_pulse: assert property (p_ready_pulse) else $error("long ready");
	a_err_map: assert property (p_err_map) else $error("unmapped not refused");
	a_upper: assert property (p_upper) else $error("upper bits set");
	c_irq: cover property ($fell(irq_n));
	c_err: cover property (pslverr);
	c_clr: cover property (fl_acc && pwdata[1:0] != 2'h0);
	c_skip: cover property (rx_bit_valid && rx_framing_bit && !rx_bit);
endmodule : lcd_top_properties

// >>> verification/lcd_rx_src.sv
`timescale 1ns/1ps
module lcd_rx_src
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [1:0] mode,
	output logic rx_bit_valid,
	output logic rx_bit,
	output logic rx_framing_bit
);
	integer seed = 93546;
	logic [4:0] rnd;
	// Idle toggles, good sends ones amid zero framing bits, bad sends zeros
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_bit_valid <= 1'b0;
			rx_bit <= 1'b0;
			rx_framing_bit <= 1'b0;
		end
		else
		begin
			rnd = 5'($random(seed));
			rx_bit_valid <= mode != 2'd0;
			rx_framing_bit <= mode == 2'd1 && rnd != 5'h0;
			rx_bit <= mode == 2'd0 ? !rx_bit : mode == 2'd1 && rnd == 5'h0;
		end
	end
endmodule : lcd_rx_src

// >>> verification/lcd_top_bench.sv
`timescale 1ns/1ps
module lcd_top_bench
	import lcd_pkg::*;
;
	localparam int P = 650;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_n, vld, bv, frm, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] mode;
	logic [11:0] ad [7];
	logic [7:0] rv [7];
	logic [7:0] wv [7];
	logic [7:0] ev [7];
	int n_errors, checked, mc;
	int me [2];
	int mg [2];
	logic [1:0] mp, cb;
	lcd_top #(.PERIOD_CYCLES(P)) lcd_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_bit_valid(vld), .rx_bit(bv), .rx_framing_bit(frm), .irq_n(irq_n));
	lcd_rx_src lcd_rx_src_inst (.pclk(pclk), .presetn(presetn), .mode(mode), .rx_bit_valid(vld), .rx_bit(bv),
		.rx_framing_bit(frm));
	// Reference model of the period judgement, index 1 loop-up, 0 loop-down; cb is each code's uniform bit
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mc = 0;
			me = '{0, 0};
			mg = '{0, 0};
			mp = 2'b00;
		end
		else
		begin
			mc++;
			for (int k = 0; k < 2; k++)
			begin
				if (mc == P)
				begin
					mg[k] = (me[k] < LCD_ERR_LIMIT) ? mg[k] + 1 : 0;
					if (me[k] > LCD_ERR_LIMIT)
						mp[k] = 1'b0;
					else if (mg[k] > LCD_GOOD_RUN)
						mp[k] = 1'b1;
					me[k] = 0;
				end
				// A miss on the judging edge belongs to the next period
				me[k] += (vld && !frm && bv != cb[k]) ? 1 : 0;
			end
			if (mc == P)
				mc = 0;
		end
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task irq(input logic e);
		repeat (2) @(posedge pclk);
		chk("irq_n", {31'h0, irq_n}, {31'h0, e});
	endtask : irq
	task test_done;
		if (n_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	initial
	begin
		repeat (95000) @(posedge pclk);
		n_errors++;
		test_done;
	end
	initial
	begin
		{psel, penable, pwrite, presetn, paddr, pwdata, mode} = '0;
		cb = 2'b11;
		for (int i = 0; i < 6; i++)
			ad[i] = {2'h0, LCD_CFG_IDX + 8'(i), 2'h0};
		ad[6] = 12'h000;
		rv = '{LCD_CFG_RST, 8'h00, LCD_UP_PAT_RST, LCD_DOWN_PAT_RST, LCD_IRQ_EN_RST, 8'h00, 8'h00};
		wv = '{8'h14, 8'hff, 8'hf8, 8'hfc, 8'h02, 8'hff, 8'hff};
		ev = '{8'h14, 8'h00, 8'hf8, 8'hfc, 8'h02, 8'h00, 8'h00};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 7; i++)
		begin
			apb(1'b0, ad[i], 32'h0);
			chk("reset", rd, {24'h0, rv[i]});
			chk("slverr", {31'h0, er}, {31'h0, i == 6});
			apb(1'b1, ad[i], {24'hffffff, wv[i]});
			apb(1'b0, ad[i], 32'h0);
			chk("readback", rd, {24'h0, ev[i]});
		end
		// Loop codes with lower bits clear, framing bits skipped
		mode <= 2'd1;
		repeat (126 * P + P / 2) @(posedge pclk);
		apb(1'b0, ad[1], 32'h0);
		chk("status", rd, {30'h0, mp});
		repeat (P) @(posedge pclk);
		apb(1'b0, ad[1], 32'h0);
		chk("status", rd, {30'h0, mp});
		apb(1'b0, ad[5], 32'h0);
		chk("flags", rd, 32'h3);
		irq(1'b0);
		apb(1'b1, ad[5], 32'h0);
		irq(1'b0);
		apb(1'b1, ad[5], 32'h2);
		irq(1'b1);
		apb(1'b0, ad[5], 32'h0);
		chk("flags", rd, 32'h1);
		apb(1'b1, ad[4], 32'h3);
		irq(1'b0);
		apb(1'b1, ad[5], 32'h1);
		irq(1'b1);
		// Zero stream: the 5-bit loop-up code 00000 still matches, loop-down ones fail
		apb(1'b1, ad[2], 32'h07);
		cb <= 2'b01;
		mode <= 2'd2;
		repeat (2 * P) @(posedge pclk);
		apb(1'b0, ad[1], 32'h0);
		chk("status", rd, {30'h0, mp});
		chk("status", rd, 32'h2);
		apb(1'b0, ad[5], 32'h0);
		chk("flags", rd, 32'h1);
		irq(1'b0);
		// Loop-up code back to ones: it fails too
		apb(1'b1, ad[2], 32'hf8);
		cb <= 2'b11;
		repeat (2 * P) @(posedge pclk);
		apb(1'b0, ad[1], 32'h0);
		chk("status", rd, {30'h0, mp});
		apb(1'b0, ad[5], 32'h0);
		chk("flags", rd, 32'h3);
		irq(1'b0);
		test_done;
	end
endmodule : lcd_top_bench
bind lcd_top lcd_top_properties #(.PERIOD_CYCLES(PERIOD_CYCLES)) lcd_top_properties_inst (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
	.rx_framing_bit(rx_framing_bit), .irq_n(irq_n));
